// *** edac_pkg.sv ***
// Shared constants for the ECC storage-array controller.
// Assumes a 20 MHz core clock and a 1 us tick from the
// memory controller.
`default_nettype none
package edac_pkg;
  // Word layout
  localparam int DATA_W = 32;
  localparam int CHK_W  = 7;
  localparam int WORD_W = 39;
  localparam int LANES  = 4;
  // Address fields on the bus during a command
  localparam int ROW_W   = 7;
  localparam int COL_W   = 7;
  localparam int COL_LSB = 0;
  localparam int ROW_LSB = 7;
  localparam int BRD_LSB = 14;
  localparam int BRD_W   = 4;
  // Bus parity sense: odd
  localparam logic PAR_ODD = 1'b1;
  // Refresh timing
  localparam int TICK_US       = 1;
  localparam int REF_PERIOD_US = 16;
  localparam int REF_TICKS     = REF_PERIOD_US / TICK_US;
  localparam int CLK_NS        = 50;
  localparam int T_RAS_NS      = 100;
  localparam int RAS_CYC       = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
  // Reset values
  localparam logic [ROW_W-1:0] ROW_RST = 7'h00;
  // Access sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_HOLD = 4'h1,
    ST_RROW = 4'h2,
    ST_RCOL = 4'h3,
    ST_RDAT = 4'h4,
    ST_WTDS = 4'h5,
    ST_DRV  = 4'h6,
    ST_WROW = 4'h7,
    ST_WCOL = 4'h8,
    ST_DONE = 4'h9
  } edac_st_t;
  // Refresh sequencer states
  typedef enum logic [1:0] {
    RF_IDLE = 2'h0,
    RF_RAS  = 2'h1,
    RF_PRE  = 2'h2
  } edac_rf_t;
endpackage
`default_nettype wire

// *** edac_ctrl.sv ***
// Storage-array controller: bus sequencer, refresh, ECC, RAM strobes.
// Assumes all inputs synchronous to ref_clk and a memory controller
// that waits for acc_done before issuing the next command.
//
// Operation
// - Diagnostic mode writes raw 39-bit word
// - Generate and check parity per byte
// - Bus parity error blocks RAM write
// - Word read drives four bytes, four parities
// - Partial read drives only requested bytes
// - Word write stores bus word
// - Partial write merges bytes, regenerates check bits
// - Refresh every sixteen 1 us ticks
// - Refresh only lengthens a colliding access
// - Idle until command addressed to board
// - Wait out refresh, then read or write
// - Address to mux, read, await strobe
// - Reads gate only selected byte lanes
// - Read errors reported to memory controller
// - RAS derived from both sequencers, CAS and WE from access only
// - Refresh waits cycle, blocks new access
// - Refresh counter walks 128 rows
// - Regenerate check bits, zero syndrome clean
// - Correct single, detect double errors
// - Writes store data plus fresh check bits
// - Word is four bytes plus seven check bits
`timescale 1ns/1ps
`default_nettype none

module edac_ctrl #(
  parameter logic [edac_pkg::BRD_W-1:0] BOARD_ID = 4'h0
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // Timing and mode from memory controller
  input  wire logic                       us_tick,
  input  wire logic                       diag_full_word,
  input  wire logic [edac_pkg::CHK_W-1:0] diag_chk_in,
  // Command lines
  input  wire logic                       acc_cmd,
  input  wire logic                       acc_write,
  input  wire logic [edac_pkg::LANES-1:0] byte_sel,
  input  wire logic                       data_strobe,
  // Shared address/data bus
  input  wire logic [edac_pkg::DATA_W-1:0] sad_in,
  input  wire logic [edac_pkg::LANES-1:0]  sad_par_in,
  output logic      [edac_pkg::DATA_W-1:0] sad_out,
  output logic      [edac_pkg::LANES-1:0]  sad_par_out,
  output logic      [edac_pkg::LANES-1:0]  sad_oe,
  // Status to memory controller
  output logic                       acc_done,
  output logic                       busy,
  output logic                       err_corr,
  output logic                       err_uncorr,
  output logic                       err_parity,
  // RAM array
  output logic [edac_pkg::ROW_W-1:0]   ram_addr,
  output logic                         ram_ras_n,
  output logic                         ram_cas_n,
  output logic                         ram_we_n,
  output logic [edac_pkg::WORD_W-1:0]  ram_wdata,
  input  wire logic [edac_pkg::WORD_W-1:0] ram_rdata
);

  ////////////////////////////////////////////////////////////////////
  // Functions

  // Hamming position of data bit i (skips powers of two)
  function automatic logic [5:0] dpos(input int i);
    int n;
    int p;
    n = 0;
    dpos = 6'h00;
    for (p = 3; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (n == i) begin
          dpos = 6'(p);
        end
        n++;
      end
    end
  endfunction

  // Six Hamming bits plus overall parity
  function automatic logic [6:0] ecc_gen(input logic [31:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < 32; i++) begin
      c = c ^ (dpos(i) & {6{d[i]}});
    end
    ecc_gen = {(^d) ^ (^c), c};
  endfunction

  // Per-byte parity of a word
  function automatic logic [3:0] par_gen(input logic [31:0] d);
    for (int k = 0; k < 4; k++) begin
      par_gen[k] = (^d[8*k +: 8]) ^ edac_pkg::PAR_ODD;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // State

  edac_pkg::edac_st_t st_r, st_nxt;
  edac_pkg::edac_rf_t rf_r, rf_nxt;

  logic [3:0]                     tick_cnt_r;
  logic                           ref_pend_r;
  logic [1:0]                     ras_cnt_r;
  logic [edac_pkg::ROW_W-1:0]     ref_row_r;
  logic [edac_pkg::ROW_W-1:0]     row_r;
  logic [edac_pkg::COL_W-1:0]     col_r;
  logic                           wr_r;
  logic [edac_pkg::LANES-1:0]     bsel_r;
  logic                           perr_r;
  logic [edac_pkg::WORD_W-1:0]    rd_r;
  logic [edac_pkg::DATA_W-1:0]    sad_out_r;
  logic [edac_pkg::LANES-1:0]     sad_par_r;
  logic [edac_pkg::LANES-1:0]     sad_oe_r;
  logic                           done_r;
  logic                           busy_r;
  logic                           ecor_r;
  logic                           eunc_r;
  logic                           epar_r;
  logic [edac_pkg::ROW_W-1:0]     ram_addr_r;
  logic                           ras_n_r;
  logic                           cas_n_r;
  logic                           we_n_r;
  logic [edac_pkg::WORD_W-1:0]    wdata_r;

  ////////////////////////////////////////////////////////////////////
  // Decode

  // Incoming parity per lane
  wire [3:0] in_par_bad = par_gen(sad_in) ^ sad_par_in;
  wire brd_hit =
    (sad_in[edac_pkg::BRD_LSB +: edac_pkg::BRD_W] == BOARD_ID);
  wire cmd_take = acc_cmd && brd_hit && (st_r == edac_pkg::ST_IDLE);
  wire ds_take = (st_r == edac_pkg::ST_WTDS) && data_strobe;
  wire drv_go = ds_take && !wr_r;
  wire wr_go = ds_take && wr_r;
  // Only lanes carrying write data are judged
  wire data_perr = |(in_par_bad & bsel_r);

  // Syndrome of captured word
  wire [6:0] chk_rd = ecc_gen(rd_r[31:0]);
  wire [5:0] syn = chk_rd[5:0] ^ rd_r[37:32];
  wire       ovp = ^rd_r;
  wire       sgl = ovp;
  wire       dbl = !ovp && (syn != 6'h00);

  // Correction mask and byte merge
  logic [31:0] fix;
  logic [31:0] merged;
  wire  [31:0] cor = rd_r[31:0] ^ fix;
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_fix
      assign fix[gi] = sgl && (syn == dpos(gi));
    end
    for (gi = 0; gi < 4; gi++) begin : g_mrg
      assign merged[8*gi +: 8] =
        bsel_r[gi] ? sad_in[8*gi +: 8] : cor[8*gi +: 8];
    end
  endgenerate

  // Bypass check generator in diagnostic mode
  wire [6:0] wr_chk = diag_full_word ? diag_chk_in : ecc_gen(merged);
  wire [38:0] wr_word = {wr_chk, merged};

  // Refresh trigger and arbitration
  wire tick_wrap = us_tick &&
    (tick_cnt_r == 4'(edac_pkg::REF_TICKS - 1));
  wire bus_quiet = (st_r == edac_pkg::ST_IDLE) ||
                   (st_r == edac_pkg::ST_HOLD);
  wire ref_go = ref_pend_r && bus_quiet &&
                (rf_r == edac_pkg::RF_IDLE);
  wire ras_last = (ras_cnt_r == 2'(edac_pkg::RAS_CYC - 1));

  ////////////////////////////////////////////////////////////////////
  // Access sequencer

  // Next state; access waits behind any refresh
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      edac_pkg::ST_IDLE: begin
        if (cmd_take) begin
          st_nxt = edac_pkg::ST_HOLD;
        end
      end
      edac_pkg::ST_HOLD: begin
        if (rf_r == edac_pkg::RF_IDLE && !ref_pend_r) begin
          st_nxt = edac_pkg::ST_RROW;
        end
      end
      edac_pkg::ST_RROW: st_nxt = edac_pkg::ST_RCOL;
      edac_pkg::ST_RCOL: st_nxt = edac_pkg::ST_RDAT;
      edac_pkg::ST_RDAT: st_nxt = edac_pkg::ST_WTDS;
      edac_pkg::ST_WTDS: begin
        if (drv_go) begin
          st_nxt = edac_pkg::ST_DRV;
        end else if (wr_go) begin
          st_nxt = edac_pkg::ST_WROW;
        end
      end
      edac_pkg::ST_DRV:  st_nxt = edac_pkg::ST_DONE;
      edac_pkg::ST_WROW: st_nxt = edac_pkg::ST_WCOL;
      edac_pkg::ST_WCOL: st_nxt = edac_pkg::ST_DONE;
      default:           st_nxt = edac_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Refresh sequencer

  // RAS-only refresh of one row
  always_comb begin
    rf_nxt = rf_r;
    case (rf_r)
      edac_pkg::RF_IDLE: begin
        if (ref_go) begin
          rf_nxt = edac_pkg::RF_RAS;
        end
      end
      edac_pkg::RF_RAS: begin
        if (ras_last) begin
          rf_nxt = edac_pkg::RF_PRE;
        end
      end
      default: rf_nxt = edac_pkg::RF_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // RAM strobe decode, taken from next states so pins match states

  wire acc_ras = (st_nxt == edac_pkg::ST_RROW) ||
                 (st_nxt == edac_pkg::ST_RCOL) ||
                 (st_nxt == edac_pkg::ST_RDAT) ||
                 (st_nxt == edac_pkg::ST_WROW) ||
                 (st_nxt == edac_pkg::ST_WCOL);
  wire acc_cas = (st_nxt == edac_pkg::ST_RCOL) ||
                 (st_nxt == edac_pkg::ST_RDAT) ||
                 (st_nxt == edac_pkg::ST_WCOL);
  wire ref_ras = (rf_nxt == edac_pkg::RF_RAS);
  wire ras_n_nxt = !(acc_ras || ref_ras);
  wire cas_n_nxt = !acc_cas;
  // Parity fault keeps write strobe high
  wire we_n_nxt = !((st_nxt == edac_pkg::ST_WCOL) && !perr_r);
  wire [6:0] addr_nxt = ref_ras ? ref_row_r :
                        acc_cas ? col_r : row_r;

  ////////////////////////////////////////////////////////////////////
  // Sequencer registers

  // States and refresh timing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r       <= edac_pkg::ST_IDLE;
      rf_r       <= edac_pkg::RF_IDLE;
      tick_cnt_r <= 4'h0;
      ref_pend_r <= 1'b0;
      ras_cnt_r  <= 2'h0;
      ref_row_r  <= edac_pkg::ROW_RST;
    end else begin
      st_r <= st_nxt;
      rf_r <= rf_nxt;
      if (us_tick) begin
        tick_cnt_r <= tick_wrap ? 4'h0 : tick_cnt_r + 4'h1;
      end
      ref_pend_r <= tick_wrap || (ref_pend_r && !ref_go);
      ras_cnt_r <= (rf_r == edac_pkg::RF_RAS) ? ras_cnt_r + 2'h1 : 2'h0;
      if (rf_r == edac_pkg::RF_PRE) begin
        ref_row_r <= ref_row_r + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Access data path

  // Latch command, read word and parity status
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      row_r  <= 7'h00;
      col_r  <= 7'h00;
      wr_r   <= 1'b0;
      bsel_r <= 4'h0;
      perr_r <= 1'b0;
      rd_r   <= 39'h0;
    end else begin
      if (cmd_take) begin
        row_r  <= sad_in[edac_pkg::ROW_LSB +: edac_pkg::ROW_W];
        col_r  <= sad_in[edac_pkg::COL_LSB +: edac_pkg::COL_W];
        wr_r   <= acc_write;
        bsel_r <= byte_sel;
        perr_r <= |in_par_bad;
      end else if (wr_go) begin
        perr_r <= perr_r || data_perr;
      end
      if (st_r == edac_pkg::ST_RDAT) begin
        rd_r <= ram_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus drive and status

  // Read lanes stand one cycle with acc_done
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sad_out_r <= 32'h0;
      sad_par_r <= 4'h0;
      sad_oe_r  <= 4'h0;
      done_r    <= 1'b0;
      busy_r    <= 1'b0;
      ecor_r    <= 1'b0;
      eunc_r    <= 1'b0;
      epar_r    <= 1'b0;
    end else begin
      sad_oe_r <= drv_go ? bsel_r : 4'h0;
      if (drv_go) begin
        sad_out_r <= cor;
        sad_par_r <= par_gen(cor);
      end
      done_r <= drv_go || (st_r == edac_pkg::ST_WCOL);
      busy_r <= (st_nxt != edac_pkg::ST_IDLE);
      if (drv_go || st_r == edac_pkg::ST_WCOL) begin
        ecor_r <= sgl;
        eunc_r <= dbl;
        epar_r <= perr_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // RAM pins

  // Strobes idle high
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ram_addr_r <= 7'h00;
      ras_n_r    <= 1'b1;
      cas_n_r    <= 1'b1;
      we_n_r     <= 1'b1;
      wdata_r    <= 39'h0;
    end else begin
      ram_addr_r <= addr_nxt;
      ras_n_r    <= ras_n_nxt;
      cas_n_r    <= cas_n_nxt;
      we_n_r     <= we_n_nxt;
      if (wr_go) begin
        wdata_r <= wr_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign sad_out     = sad_out_r;
  assign sad_par_out = sad_par_r;
  assign sad_oe      = sad_oe_r;
  assign acc_done    = done_r;
  assign busy        = busy_r;
  assign err_corr    = ecor_r;
  assign err_uncorr  = eunc_r;
  assign err_parity  = epar_r;
  assign ram_addr    = ram_addr_r;
  assign ram_ras_n   = ras_n_r;
  assign ram_cas_n   = cas_n_r;
  assign ram_we_n    = we_n_r;
  assign ram_wdata   = wdata_r;

endmodule
`default_nettype wire

// *** edac_ctrl_monitor.sv ***
// Port checker for the storage-array controller.
// Assumes it is bound onto edac_ctrl; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module edac_ctrl_monitor #(
  parameter logic [3:0] BOARD_ID = 4'h0
) (
  // Clock, reset and tick
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        us_tick,
  // Command side
  input wire logic        acc_cmd,
  input wire logic        acc_write,
  input wire logic [3:0]  byte_sel,
  input wire logic        data_strobe,
  input wire logic [31:0] sad_in,
  // Answers
  input wire logic [31:0] sad_out,
  input wire logic [3:0]  sad_par_out,
  input wire logic [3:0]  sad_oe,
  input wire logic        acc_done,
  input wire logic        busy,
  input wire logic        err_corr,
  input wire logic        err_uncorr,
  input wire logic        err_parity,
  // RAM strobes
  input wire logic        ram_ras_n,
  input wire logic        ram_cas_n,
  input wire logic        ram_we_n
);
  ////////////////////////////////////////
  logic       take, ref_end, rst_d, ras_q, cas_q, wr_r, we_seen_r;
  logic [3:0] sel_r, par_x;
  logic [4:0] tk_r;
  // Accepted command; a refresh ends as ras rises with cas idle
  assign take    = acc_cmd && !busy && (sad_in[17:14] == BOARD_ID);
  assign ref_end = ram_ras_n && !ras_q && cas_q;
  for (genvar k = 0; k < 4; k++) begin : g_par
    assign par_x[k] = ~^sad_out[8*k+:8];
  end
  // Reset shadow keeps $past off values from before a reset
  always_ff @(posedge ref_clk) begin
    rst_d <= rst;
    ras_q <= ram_ras_n;
    cas_q <= ram_cas_n;
    if (rst || take) begin
      we_seen_r <= 1'b0;
    end else if (!ram_we_n) begin
      we_seen_r <= 1'b1;
    end
    if (take) begin
      wr_r  <= acc_write;
      sel_r <= byte_sel;
    end
    if (rst) begin
      tk_r <= 5'h00;
    end else if (ref_end) begin
      tk_r <= 5'(us_tick);
    end else begin
      tk_r <= tk_r + 5'(us_tick);
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst || rst_d);
  AST_TAKE_BUSY: assert property (take |=> busy)
    else $error("command taken but busy stayed low");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(take))
    else $error("busy rose without an accepted command");
  AST_OE_READ: assert property (sad_oe != 4'h0 |-> acc_done && !wr_r && sad_oe == sel_r)
    else $error("lane drive does not match a read select");
  AST_OE_ONE: assert property (sad_oe != 4'h0 |=> sad_oe == 4'h0)
    else $error("lane drive held past one cycle");
  AST_PAR_OUT: assert property (sad_oe != 4'h0 |-> ((sad_par_out ^ par_x) & sad_oe) == 4'h0)
    else $error("driven byte carries wrong parity");
  AST_RD_STROBE: assert property (acc_done && !wr_r |-> $past(data_strobe))
    else $error("read answered without data strobe");
  AST_WE_CAS: assert property (!ram_we_n |-> !ram_cas_n && wr_r)
    else $error("write strobe outside a write column cycle");
  AST_PAR_BLOCK: assert property (acc_done && err_parity |-> !we_seen_r)
    else $error("RAM written despite bus parity error");
  AST_ERR_HOLD: assert property (!acc_done |-> $stable({err_corr, err_uncorr}))
    else $error("error status moved without a completion");
  AST_REF_GAP: assert property (ref_end |-> tk_r >= 5'h0f && tk_r <= 5'h11)
    else $error("refresh spacing off sixteen ticks");
  AST_REF_MAX: assert property (tk_r <= 5'h11)
    else $error("refresh overdue");
  AST_REF_RAS: assert property (ref_end |-> !$past(ram_ras_n, 2) && $past(ram_ras_n, 3))
    else $error("refresh row strobe not two cycles");
  COV_READ: cover property (sad_oe != 4'h0);
  COV_PAR: cover property (acc_done && err_parity);
  COV_REF: cover property (ref_end);
  COV_CORR: cover property (acc_done && err_corr);
endmodule

bind edac_ctrl edac_ctrl_monitor #(.BOARD_ID(BOARD_ID)) edac_ctrl_monitor_inst (
  .ref_clk, .rst, .us_tick, .acc_cmd, .acc_write, .byte_sel, .data_strobe, .sad_in,
  .sad_out, .sad_par_out, .sad_oe, .acc_done, .busy, .err_corr, .err_uncorr,
  .err_parity, .ram_ras_n, .ram_cas_n, .ram_we_n);
`default_nettype wire

// *** edac_mc_model.sv ***
// Memory controller model: array commands and the 1 us tick.
// Assumes callers run in ref_clk context, one command at a time.
`timescale 1ns/1ps
`default_nettype none
module edac_mc_model (
  // Clock
  input wire logic        ref_clk,
  // Mode, tick and command drive
  output logic            us_tick,
  output logic            diag_full_word,
  output logic [6:0]      diag_chk_in,
  output logic            acc_cmd,
  output logic            acc_write,
  output logic [3:0]      byte_sel,
  output logic            data_strobe,
  output logic [31:0]     sad_in,
  output logic [3:0]      sad_par_in,
  // Answers from the board
  input wire logic [31:0] sad_out,
  input wire logic [3:0]  sad_par_out,
  input wire logic [3:0]  sad_oe,
  input wire logic        acc_done,
  input wire logic        busy
);
  int tick_cnt;
  // Idle levels at time zero
  initial begin
    {us_tick, diag_full_word, diag_chk_in, acc_cmd, acc_write, byte_sel, data_strobe} = '0;
    sad_in = 32'h5a5a_0f0f;
    sad_par_in = 4'h0;
    tick_cnt = 0;
  end
  // One-cycle tick every 20 clocks
  always @(posedge ref_clk) begin
    tick_cnt <= (tick_cnt == 19) ? 0 : tick_cnt + 1;
    us_tick <= (tick_cnt == 19);
  end
  ////////////////////////////////////////
  function automatic logic [3:0] opar(input logic [31:0] d);
    for (int k = 0; k < 4; k++) begin
      opar[k] = ~^d[8*k+:8];
    end
  endfunction
  // Mode only changes between accesses
  task automatic set_diag(input logic on, input logic [6:0] chk);
    @(posedge ref_clk);
    diag_full_word <= on;
    diag_chk_in    <= chk;
  endtask
  // Full command: address phase, strobe with data, answer at done
  task automatic access(input logic wr, input logic [3:0] sel, input logic [3:0] brd,
                        input logic [13:0] adr, input logic [31:0] dat, input logic [7:0] pf,
                        output logic [31:0] q, output logic [3:0] oe, output logic [3:0] qp,
                        output logic ok);
    logic [31:0] cmd;
    cmd = {14'h0000, brd, adr};
    ok = 1'b0;
    @(posedge ref_clk);
    acc_cmd    <= 1'b1;
    acc_write  <= wr;
    byte_sel   <= sel;
    sad_in     <= cmd;
    sad_par_in <= opar(cmd) ^ pf[7:4];
    // Command stands until busy shows it was taken, four clocks at most
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge ref_clk);
      ok = busy;
    end
    acc_cmd     <= 1'b0;
    sad_in      <= dat;
    sad_par_in  <= opar(dat) ^ pf[3:0];
    data_strobe <= ok;
    for (int n = 0; n < 60 && ok && !acc_done; n++) begin
      @(posedge ref_clk);
    end
    q  = sad_out;
    oe = sad_oe;
    qp = sad_par_out;
    ok = ok && acc_done;
    // Released lines show no stale data
    data_strobe <= 1'b0;
    sad_in      <= ~dat;
    sad_par_in  <= ~sad_par_in;
    for (int n = 0; n < 8 && busy; n++) begin
      @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// *** test_edac_ctrl.sv ***
// Self-checking bench for edac_ctrl with controller model and RAM.
// Assumes edac_pkg, the monitor and the controller model compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_edac_ctrl;
  localparam logic [3:0] BID = 4'h5;
  logic        ref_clk, rst, us_tick, diag_full_word, acc_cmd, acc_write, data_strobe, ok;
  logic        acc_done, busy, err_corr, err_uncorr, err_parity, ram_ras_n, ram_cas_n;
  logic        ram_we_n, ras_q, cas_q, had_cas;
  logic [6:0]  diag_chk_in, ram_addr, row_r, col_r, ref_exp, chk;
  logic [3:0]  byte_sel, sad_par_in, sad_par_out, sad_oe, oe, qp;
  logic [31:0] sad_in, sad_out, q, m;
  logic [38:0] ram_wdata, ram_rdata;
  logic [38:0] mem [0:16383];
  int          mismatches, checked;
  typedef struct {
    logic wr; logic [3:0] sel; logic [13:0] adr; logic [31:0] dat; logic [7:0] pf; logic ep;
  } edac_row_t;
  // Write, merge, read and parity-fault rows; read rows hold masked data
  edac_row_t rows [13] = '{
    '{1, 4'hf, 14'h0005, 32'h11223344, 8'h00, 0}, '{0, 4'hf, 14'h0005, 32'h11223344, 8'h00, 0},
    '{1, 4'h2, 14'h0005, 32'h0000aa00, 8'h00, 0}, '{0, 4'hf, 14'h0005, 32'h1122aa44, 8'h00, 0},
    '{0, 4'h1, 14'h0005, 32'h00000044, 8'h00, 0}, '{1, 4'he, 14'h0005, 32'h5566bb00, 8'h00, 0},
    '{0, 4'h6, 14'h0005, 32'h0066bb00, 8'h00, 0}, '{1, 4'hf, 14'h3fff, 32'h01020304, 8'h00, 0},
    '{1, 4'hf, 14'h3fff, 32'hdeadbeef, 8'h04, 1}, '{1, 4'hf, 14'h3fff, 32'hdeadbeef, 8'h10, 1},
    '{0, 4'hf, 14'h3fff, 32'h01020304, 8'h00, 0}, '{1, 4'h8, 14'h3fff, 32'h77000000, 8'h01, 0},
    '{0, 4'hb, 14'h3fff, 32'h77000304, 8'h00, 0}};

  edac_ctrl #(.BOARD_ID(BID)) edac_ctrl_inst (
    .ref_clk, .rst, .us_tick, .diag_full_word, .diag_chk_in, .acc_cmd, .acc_write,
    .byte_sel, .data_strobe, .sad_in, .sad_par_in, .sad_out, .sad_par_out, .sad_oe,
    .acc_done, .busy, .err_corr, .err_uncorr, .err_parity, .ram_addr, .ram_ras_n,
    .ram_cas_n, .ram_we_n, .ram_wdata, .ram_rdata);
  edac_mc_model edac_mc_model_inst (
    .ref_clk, .us_tick, .diag_full_word, .diag_chk_in, .acc_cmd, .acc_write, .byte_sel,
    .data_strobe, .sad_in, .sad_par_in, .sad_out, .sad_par_out, .sad_oe, .acc_done, .busy);
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [38:0] e, input logic [38:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Clock at 50 ns
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // RAM: row at ras fall, column at cas fall; data is valid a cycle later
  assign ram_rdata = mem[{row_r, col_r}];
  // Start from clean words; unwritten cells would make the first word write's read flag unknowns
  initial foreach (mem[i]) mem[i] = '0;
  initial {ras_q, cas_q, had_cas, ref_exp} = {3'b111, edac_pkg::ROW_RST};
  always @(posedge ref_clk) begin
    ras_q <= ram_ras_n;
    cas_q <= ram_cas_n;
    if (!ram_ras_n && ras_q) begin
      row_r   <= ram_addr;
      had_cas <= 1'b0;
    end
    if (!ram_cas_n) had_cas <= 1'b1;
    if (!ram_cas_n && cas_q) col_r <= ram_addr;
    if (!ram_cas_n && !ram_we_n) mem[{row_r, ram_addr}] <= ram_wdata;
    // A ras pulse without cas is a refresh; rows advance by one
    if (ram_ras_n && !ras_q && !had_cas) begin
      check("refresh_row", ref_exp, row_r);
      ref_exp <= ref_exp + 7'h01;
    end
    if (rst) ref_exp <= edac_pkg::ROW_RST;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    give_verdict();
  end
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    mismatches = 0;
    checked = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    check("reset", 9'h1c0, {ram_ras_n, ram_cas_n, ram_we_n, acc_done, busy, sad_oe});
    foreach (rows[i]) begin
      edac_mc_model_inst.access(rows[i].wr, rows[i].sel, BID, rows[i].adr, rows[i].dat,
                                rows[i].pf, q, oe, qp, ok);
      m = {{8{rows[i].sel[3]}}, {8{rows[i].sel[2]}}, {8{rows[i].sel[1]}}, {8{rows[i].sel[0]}}};
      check("taken", 1'b1, ok);
      check("err_parity", rows[i].ep, err_parity);
      if (!rows[i].wr) begin
        check("rd_data", rows[i].dat, q & m);
        check("rd_lanes", rows[i].sel, oe);
        check("rd_par", edac_mc_model_inst.opar(q) & oe, qp & oe);
        check("rd_err", 2'b00, {err_corr, err_uncorr});
      end
    end
    // Another board's command is ignored
    edac_mc_model_inst.access(0, 4'hf, BID ^ 4'h1, 14'h0005, '0, 8'h00, q, oe, qp, ok);
    check("refused", 1'b0, ok);
    // One flipped bit is corrected, a second one is only flagged
    mem[14'h0005][9] = ~mem[14'h0005][9];
    edac_mc_model_inst.access(0, 4'hf, BID, 14'h0005, '0, 8'h00, q, oe, qp, ok);
    check("corr_data", 32'h5566bb44, q);
    check("corr_flag", 2'b10, {err_corr, err_uncorr});
    mem[14'h0005][20] = ~mem[14'h0005][20];
    edac_mc_model_inst.access(0, 4'hf, BID, 14'h0005, '0, 8'h00, q, oe, qp, ok);
    check("uncorr_flag", 2'b01, {err_corr, err_uncorr});
    // Raw word with one check bit off, then a normal read of it
    edac_mc_model_inst.access(1, 4'hf, BID, 14'h0200, 32'h0f0f0f0f, 8'h00, q, oe, qp, ok);
    chk = mem[14'h0200][38:32] ^ 7'h01;
    edac_mc_model_inst.set_diag(1'b1, chk);
    edac_mc_model_inst.access(1, 4'hf, BID, 14'h0200, 32'h0f0f0f0f, 8'h00, q, oe, qp, ok);
    check("raw_word", {chk, 32'h0f0f0f0f}, mem[14'h0200]);
    edac_mc_model_inst.set_diag(1'b0, 7'h00);
    edac_mc_model_inst.access(0, 4'hf, BID, 14'h0200, '0, 8'h00, q, oe, qp, ok);
    check("raw_read", {1'b1, 32'h0f0f0f0f}, {err_corr, q});
    // Back-to-back reads running through refreshes only take longer
    for (int n = 0; n < 60; n++) begin
      edac_mc_model_inst.access(0, 4'hf, BID, 14'h3fff, '0, 8'h00, q, oe, qp, ok);
      check("b2b_read", {1'b1, 32'h77020304}, {ok, q});
    end
    give_verdict();
  end
endmodule
`default_nettype wire
